/* logic/accum_move_or_decoder.sv */
// Overview of operation
// - decode or-immediate, or accumulator with immediate
// - or result to accumulator, zero flag updated
// - decode move-file, read addressed file register
// - dest bit 0 to accumulator, 1 back
// - move-file always updates zero flag
// - store accumulator to file, flags untouched
// - option-load copies accumulator, flags untouched
// - option register reachable by file address
`include "accum_move_or_defs.svh"

module accum_move_or_decoder (
	input wire logic core_clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic instr_valid_i,
	input wire logic [`INSTR_W-1:0] instr_word_i,
	input wire logic [`DATA_W-1:0] file_rd_data_i,
	output logic instr_ready_o,
	output accum_move_or_pkg::file_req_type file_req_o,
	output logic [`DATA_W-1:0] accum_o,
	output logic zero_o,
	output logic [`DATA_W-1:0] option_o,
	output logic done_o,
	output logic unsupported_o
);
	import accum_move_or_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	state_type state_q, state_d;
	decoded_type cur_q, dec;
	file_req_type file_req_q, file_req_d;
	logic [`DATA_W-1:0] w_q, w_d, option_q, option_d;
	logic z_q, z_d, ready_q, done_q, unsup_q;

	// pure decode with no state, so a word is classified in the cycle it is offered
	instr_classify u_classify (
		.word_i(instr_word_i),
		.dec_o(dec)
	);

	// ----------------------------------------------------------------
	// decode of the latched word
	// ----------------------------------------------------------------
	wire logic accept = ce_i && (state_q == S_DECODE) && instr_valid_i;
	wire logic exec_fire = ce_i && (state_q == S_EXEC);
	wire logic is_or = exec_fire && (cur_q.op == OP_OR_IMM);
	wire logic is_move = exec_fire && (cur_q.op == OP_MOVE_FILE);
	wire logic is_store = exec_fire && (cur_q.op == OP_STORE_ACCUM);
	wire logic is_optload = exec_fire && (cur_q.op == OP_OPTION_LOAD);
	wire logic is_nop = exec_fire && (cur_q.op == OP_NOP);
	wire logic is_none = exec_fire && (cur_q.op == OP_NONE);

	// option register answers at its file address instead of the outside file
	wire logic opt_hit = cur_q.faddr == `OPTION_FADDR;
	wire logic [`DATA_W-1:0] read_val = opt_hit ? option_q : file_rd_data_i;
	wire logic [`DATA_W-1:0] or_result = w_q | cur_q.imm;
	wire logic move_to_w = is_move && !cur_q.to_file;
	wire logic move_back = is_move && cur_q.to_file;

	// ----------------------------------------------------------------
	// next values
	// ----------------------------------------------------------------
	assign w_d = is_or ? or_result :
		move_to_w ? read_val : w_q;
	assign z_d = is_or ? (or_result == '0) :
		is_move ? (read_val == '0) : z_q;
	// option writes stay inside the block and never reach the outside file
	assign option_d = is_optload ? w_q :
		(is_store && opt_hit) ? w_q :
		(move_back && opt_hit) ? read_val : option_q;

	// ----------------------------------------------------------------
	// file request
	// ----------------------------------------------------------------
	wire logic file_wr = (is_store || move_back) && !opt_hit;
	assign file_req_d.wr_en = file_wr;
	assign file_req_d.addr = accept ? dec.faddr : file_req_q.addr;
	assign file_req_d.data = !file_wr ? file_req_q.data :
		is_store ? w_q : read_val;

	// ----------------------------------------------------------------
	// sequencing
	// ----------------------------------------------------------------
	// one clock to take the word, one to execute it
	always_comb begin
		state_d = state_q;
		case (state_q)
			S_DECODE: begin
				if (accept) begin
					state_d = S_EXEC;
				end
			end
			S_EXEC: begin
				if (exec_fire) begin
					state_d = S_DECODE;
				end
			end
			// a stray code falls back to decode rather than hanging
			default: begin
				state_d = S_DECODE;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q <= S_DECODE;
			ready_q <= 1'b1;
			done_q <= 1'b0;
			unsup_q <= 1'b0;
		end else if (ce_i) begin
			state_q <= state_d;
			ready_q <= state_d == S_DECODE;
			done_q <= exec_fire;
			unsup_q <= is_none;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cur_q <= '0;
			file_req_q <= '0;
		end else if (ce_i) begin
			if (accept) begin
				cur_q <= dec;
			end
			file_req_q <= file_req_d;
		end
	end

	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			w_q <= `ACCUM_RESET;
			z_q <= `ZERO_RESET;
			option_q <= `OPTION_RESET;
		end else if (ce_i) begin
			w_q <= w_d;
			z_q <= z_d;
			option_q <= option_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign instr_ready_o = ready_q;
	assign file_req_o = file_req_q;
	assign accum_o = w_q;
	assign zero_o = z_q;
	assign option_o = option_q;
	assign done_o = done_q;
	assign unsupported_o = unsup_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);

	or_imm_result_a: assert property (is_or |=> w_q == $past(or_result))
		else $error("or-immediate result wrong");
	or_zero_flag_a: assert property (is_or |=> z_q == ($past(or_result) == '0))
		else $error("or-immediate zero flag wrong");
	move_read_addr_a: assert property (is_move |-> file_req_q.addr == cur_q.faddr)
		else $error("move-file reads wrong address");
	move_to_accum_a: assert property (move_to_w |=> w_q == $past(read_val) && !file_req_q.wr_en)
		else $error("move-file to accumulator wrong");
	move_write_back_a: assert property (move_back && !opt_hit |=>
		file_req_q.wr_en && file_req_q.data == $past(read_val) && $stable(w_q))
		else $error("move-file write back wrong");
	move_zero_flag_a: assert property (is_move |=> z_q == ($past(read_val) == '0))
		else $error("move-file zero flag wrong");
	store_flags_kept_a: assert property (is_store |=> $stable(z_q) &&
		(file_req_q.wr_en ? file_req_q.data == $past(w_q) : option_q == $past(w_q)))
		else $error("store accumulator wrong");
	option_load_a: assert property (is_optload |=> option_q == $past(w_q) && $stable(z_q))
		else $error("option-load wrong");
	option_file_read_a: assert property (is_move && opt_hit && !cur_q.to_file |=>
		w_q == $past(option_q))
		else $error("option not read at its file address");
	option_no_wr_a: assert property ((is_store || move_back) && opt_hit |=>
		!file_req_q.wr_en)
		else $error("option write leaked to outside file");
	store_addr_a: assert property (is_store && !opt_hit |=>
		file_req_q.addr == $past(cur_q.faddr))
		else $error("store accumulator wrong address");
	nop_quiet_a: assert property (is_nop |=> $stable(w_q) && $stable(z_q) &&
		$stable(option_q) && !file_req_q.wr_en)
		else $error("no-operation changed state");
	unknown_quiet_a: assert property (is_none |=> unsupported_o && $stable(w_q) && $stable(z_q) &&
		$stable(option_q) && !file_req_q.wr_en)
		else $error("unsupported word changed state");
	one_cycle_exec_a: assert property (accept |=> state_q == S_EXEC)
		else $error("accepted word did not enter execute");
	exec_done_a: assert property (exec_fire |=> done_q && instr_ready_o)
		else $error("instruction did not finish in one cycle");
	// a word offered while busy is dropped, never queued
	busy_refuse_a: assert property (state_q == S_EXEC && instr_valid_i |=> $stable(cur_q))
		else $error("word taken while busy");
	// pulses must hold through a freeze, not drop
	freeze_hold_a: assert property (!ce_i |=> $stable(state_q) && $stable(w_q) && $stable(z_q) &&
		$stable(option_q) && $stable(done_q) && $stable(file_req_q))
		else $error("state moved while clock enable low");

	// ----------------------------------------------------------------
	// covers
	// ----------------------------------------------------------------
	or_seen_c: cover property (is_or ##1 accept);
	move_back_c: cover property (move_back && !opt_hit);
	option_load_c: cover property (is_optload ##2 is_move && opt_hit);
	back_to_back_c: cover property (accept ##2 accept);
	freeze_c: cover property (!ce_i && state_q == S_EXEC);

endmodule

/* logic/accum_move_or_defs.svh */
`ifndef ACCUM_MOVE_OR_DEFS_SVH
`define ACCUM_MOVE_OR_DEFS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define INSTR_W 14
`define DATA_W 8
`define FADDR_W 7

// ----------------------------------------------------------------
// instruction patterns, compared under a mask except option-load, which is matched whole
// ----------------------------------------------------------------
`define OR_IMM_MASK 14'h3F00
`define OR_IMM_MATCH 14'h3800
`define MOVE_FILE_MASK 14'h3F00
`define MOVE_FILE_MATCH 14'h0800
`define STORE_ACCUM_MASK 14'h3F80
`define STORE_ACCUM_MATCH 14'h0080
`define NOP_MASK 14'h3F9F
`define NOP_MATCH 14'h0000
`define OPTION_LOAD_WORD 14'h0062

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define DEST_BIT 7
`define FADDR_LSB 0
`define IMM_LSB 0

// ----------------------------------------------------------------
// file map and reset values
// ----------------------------------------------------------------
`define OPTION_FADDR 7'h01
`define ACCUM_RESET 8'h00
`define OPTION_RESET 8'hFF
`define ZERO_RESET 1'b0

`endif

/* logic/accum_move_or_pkg.sv */
`include "accum_move_or_defs.svh"

package accum_move_or_pkg;

	typedef enum logic [2:0] {
		OP_NONE = 3'h0,
		OP_OR_IMM = 3'h1,
		OP_MOVE_FILE = 3'h2,
		OP_STORE_ACCUM = 3'h3,
		OP_NOP = 3'h4,
		OP_OPTION_LOAD = 3'h5
	} op_type;

	typedef enum logic [1:0] {
		S_DECODE = 2'b01,
		S_EXEC = 2'b10
	} state_type;

	typedef struct packed {
		op_type op;
		logic to_file;
		logic [`FADDR_W-1:0] faddr;
		logic [`DATA_W-1:0] imm;
	} decoded_type;

	typedef struct packed {
		logic wr_en;
		logic [`FADDR_W-1:0] addr;
		logic [`DATA_W-1:0] data;
	} file_req_type;

endpackage

/* logic/instr_classify.sv */
`include "accum_move_or_defs.svh"

module instr_classify (
	input wire logic [`INSTR_W-1:0] word_i,
	output accum_move_or_pkg::decoded_type dec_o
);
	import accum_move_or_pkg::*;

	wire logic hit_or = (word_i & `OR_IMM_MASK) == `OR_IMM_MATCH;
	wire logic hit_move = (word_i & `MOVE_FILE_MASK) == `MOVE_FILE_MATCH;
	wire logic hit_store = (word_i & `STORE_ACCUM_MASK) == `STORE_ACCUM_MATCH;
	// two don't-care bits are masked out of the compare
	wire logic hit_nop = (word_i & `NOP_MASK) == `NOP_MATCH;
	wire logic hit_opt = word_i == `OPTION_LOAD_WORD;

	op_type op_sel;
	assign op_sel = hit_or ? OP_OR_IMM :
		hit_move ? OP_MOVE_FILE :
		hit_store ? OP_STORE_ACCUM :
		hit_nop ? OP_NOP :
		hit_opt ? OP_OPTION_LOAD : OP_NONE;

	assign dec_o.op = op_sel;
	assign dec_o.to_file = word_i[`DEST_BIT];
	assign dec_o.faddr = word_i[`FADDR_LSB +: `FADDR_W];
	assign dec_o.imm = word_i[`IMM_LSB +: `DATA_W];

endmodule

/* verif/file_reg_model.sv */
`include "accum_move_or_defs.svh"

module file_reg_model (
	input wire logic core_clk_i,
	input wire logic ce_i,
	input wire accum_move_or_pkg::file_req_type file_req_i,
	output logic [`DATA_W-1:0] rd_data_o
);
	timeunit 1ns;
	timeprecision 100ps;
	import accum_move_or_pkg::*;
	logic [`DATA_W-1:0] mem [0:127];
	// read is combinational: the decoder samples it in its execute cycle
	assign rd_data_o = mem[file_req_i.addr];
	// seeded so that address 7'h5A holds zero for the flag tests
	initial begin
		for (int i = 0; i < 128; i++)
			mem[i] = 8'(i) ^ 8'h5A;
	end
	always @(posedge core_clk_i) begin
		if (ce_i && file_req_i.wr_en)
			mem[file_req_i.addr] <= file_req_i.data;
	end
endmodule

/* verif/accum_move_or_decoder_tb_top.sv */
`include "accum_move_or_defs.svh"

module accum_move_or_decoder_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import accum_move_or_pkg::*;
	logic core_clk_i, rst_n_i, instr_valid_i, instr_ready_o, zero_o, done_o, unsupported_o, e_z;
	logic ce_i, stall;
	logic [`INSTR_W-1:0] instr_word_i, w;
	logic [`DATA_W-1:0] rd_data, accum_o, option_o, e_acc, e_opt;
	logic [`DATA_W-1:0] e_mem [0:127];
	logic [31:0] r;
	file_req_type file_req_o;
	int n_fail, num_checks, seed;
	// the store to 7'h01 reaches the option register by direct address
	logic [13:0] corner [13] = '{14'h389A, 14'h3835, 14'h085A, 14'h3800, 14'h0081, 14'h38C3, 14'h0062,
		14'h0801, 14'h08DA, 14'h0060, 14'h0008, 14'h00FF, 14'h08FF};

	accum_move_or_decoder u_dut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
		.instr_valid_i(instr_valid_i), .instr_word_i(instr_word_i), .file_rd_data_i(rd_data),
		.instr_ready_o(instr_ready_o), .file_req_o(file_req_o), .accum_o(accum_o), .zero_o(zero_o),
		.option_o(option_o), .done_o(done_o), .unsupported_o(unsupported_o));
	file_reg_model u_file (.core_clk_i(core_clk_i), .ce_i(ce_i), .file_req_i(file_req_o), .rd_data_o(rd_data));

	// ----
	// compare and verdict
	// ----
	task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic chk1(input string nm, input logic exp, input logic got);
		chk8(nm, {7'h00, exp}, {7'h00, got});
	endtask
	task automatic print_verdict();
		if (n_fail == 0 && num_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ----
	// one instruction, with a junk word offered while busy
	// ----
	task automatic run(input logic [13:0] wd_in);
		logic [7:0] v, wd;
		logic [6:0] a;
		logic wr, un;
		a = wd_in[6:0];
		wr = 1'b0;
		wd = 8'h00;
		un = 1'b0;
		v = (a == `OPTION_FADDR) ? e_opt : e_mem[a];
		if (wd_in[13:8] == 6'h38) begin
			e_acc = e_acc | wd_in[7:0];
			e_z = (e_acc == 8'h00);
		end else if (wd_in[13:8] == 6'h08) begin
			e_z = (v == 8'h00);
			wr = wd_in[7];
			wd = v;
			if (!wd_in[7])
				e_acc = v;
		end else if (wd_in[13:7] == 7'h01) begin
			wr = 1'b1;
			wd = e_acc;
		end else if (wd_in == 14'h0062)
			e_opt = e_acc;
		else if ((wd_in & 14'h3F9F) != 14'h0000)
			un = 1'b1;
		if (wr && a == `OPTION_FADDR) begin
			e_opt = wd;
			wr = 1'b0;
		end
		if (wr)
			e_mem[a] = wd;
		chk1("ready", 1'b1, instr_ready_o);
		instr_word_i = wd_in;
		instr_valid_i = 1'b1;
		@(posedge core_clk_i);
		#1;
		instr_word_i = 14'h3FFF;
		chk1("done_early", 1'b0, done_o);
		chk1("ready_busy", 1'b0, instr_ready_o);
		if (stall) begin
			ce_i = 1'b0;
			repeat (2) @(posedge core_clk_i);
			#1;
			chk1("done_frozen", 1'b0, done_o);
			chk1("ready_frozen", 1'b0, instr_ready_o);
			ce_i = 1'b1;
		end
		@(posedge core_clk_i);
		#1;
		chk1("done", 1'b1, done_o);
		chk1("unsupported", un, unsupported_o);
		chk8("accum", e_acc, accum_o);
		chk1("zero", e_z, zero_o);
		chk8("option", e_opt, option_o);
		chk8("file_addr", {1'b0, a}, {1'b0, file_req_o.addr});
		chk1("file_wr_en", wr, file_req_o.wr_en);
		if (wr)
			chk8("file_wr_data", wd, file_req_o.data);
	endtask

	initial begin
		core_clk_i = 1'b0;
		forever #20 core_clk_i = ~core_clk_i;
	end
	initial begin
		#(40 * 3000);
		n_fail++;
		print_verdict();
	end
	initial begin
		seed = 32'h0475;
		ce_i = 1'b1;
		stall = 1'b0;
		rst_n_i = 1'b0;
		instr_valid_i = 1'b0;
		instr_word_i = 14'h0000;
		e_acc = `ACCUM_RESET;
		e_opt = `OPTION_RESET;
		e_z = `ZERO_RESET;
		for (int i = 0; i < 128; i++)
			e_mem[i] = 8'(i) ^ 8'h5A;
		repeat (8) @(posedge core_clk_i);
		#1;
		chk8("accum_rst", e_acc, accum_o);
		chk8("option_rst", e_opt, option_o);
		chk1("zero_rst", e_z, zero_o);
		rst_n_i = 1'b1;
		foreach (corner[i])
			run(corner[i]);
		repeat (300) begin
			r = $random(seed);
			stall = r[20] & r[21];
			case (r[18:16])
				3'h0: w = {6'h38, r[7:0]};
				3'h1, 3'h2: w = {6'h08, r[7:0]};
				3'h3: w = {7'h01, r[6:0]};
				3'h4: w = {7'h00, r[6:5], 5'h00};
				default: w = r[13:0];
			endcase
			run(w);
		end
		instr_valid_i = 1'b0;
		@(posedge core_clk_i);
		#1;
		for (int i = 0; i < 128; i++)
			chk8("file_reg", e_mem[i], u_file.mem[i]);
		print_verdict();
	end
endmodule
